// *** hdl/focus_divider.sv ***
// Signed divider producing the normalised ratio (n << 14) / d.
// Assumes start only while idle; answer stands until the next division completes.
`timescale 1ns/100ps
module focus_divider
  import focus_servo_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 start_i,
  input  wire logic signed [11:0]   num_i,
  input  wire logic        [11:0]   den_i,
  output logic signed [EW-1:0]      quot_o,
  output logic                      done_o
);

  typedef struct packed {
    logic [25:0]  rem;
    logic [15:0]  q;
    logic [4:0]   cnt;
    logic         neg;
    logic         busy;
    logic [11:0]  den;
    logic [EW-1:0] quot;
    logic         done;
  } div_t;

  div_t st_r;
  div_t st_nxt;
  logic [12:0] trial;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    trial       = '0;
    if (start_i && !st_r.busy) begin
      st_nxt.neg  = num_i[11];
      st_nxt.rem  = {14'h0000, num_i[11] ? 12'(-num_i) : 12'(num_i)};
      st_nxt.rem  = st_nxt.rem << 14;
      st_nxt.den  = (den_i == 12'h000) ? 12'h001 : den_i;
      st_nxt.q    = 16'h0000;
      st_nxt.cnt  = 5'h10;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      trial = 13'(st_r.rem[25:14]) - 13'({1'b0, st_r.den});
      if (!trial[12]) begin
        st_nxt.rem = {trial[11:0], st_r.rem[13:0]} << 1;
        st_nxt.q   = {st_r.q[14:0], 1'b1};
      end else begin
        st_nxt.rem = st_r.rem << 1;
        st_nxt.q   = {st_r.q[14:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt - 5'h01;
      if (st_r.cnt == 5'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.quot = st_r.neg ? EW'(-{1'b0, st_nxt.q[15:1]})
                               : EW'({1'b0, st_nxt.q[15:1]});
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign quot_o = st_r.quot;
  assign done_o = st_r.done;

endmodule : focus_divider

// *** hdl/focus_servo.sv ***
// Focus servo conditioning: diode signal arithmetic, converter reference
// control, focus start-up, PID loop, drop-out and restart handling.
// Assumes diode samples are asynchronous pins and coefficients are
// static words from the microcontroller latch.
`timescale 1ns/100ps
module focus_servo
  import focus_servo_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  wire diodes_t               diodes_i,
  input  wire coeffs_t               coeffs_i,
  input  wire logic                  knife_edge_i,
  input  wire logic                  focus_start_i,
  input  wire logic                  vref_cmd_i,
  input  wire vref_cmd_t             vref_op_i,
  input  wire logic                  gain_up_i,
  input  wire logic                  gain_down_i,
  input  wire logic [15:0]           new_lead_i,
  input  wire logic                  agc_enable_i,
  input  wire logic                  radial_init_i,
  output logic        [4:0]          converter_upper_reference_o,
  output logic                       vref_auto_o,
  output logic signed [EW-1:0]       normalised_focus_error_o,
  output logic signed [EW-1:0]       focus_drive_o,
  output logic signed [EW-1:0]       scaled_radial_error_o,
  output logic                       track_position_flag_o,
  output logic                       focus_ok_flag_o,
  output logic                       focus_closed_o,
  output logic                       focus_lost_o
);

  // -------------------------------------------------------------------
  // Arithmetic helpers
  // -------------------------------------------------------------------
  function automatic logic signed [EW-1:0] sat(input logic signed [39:0] v);
    if (v > 40'sd32767) return 16'sh7FFF;
    if (v < -40'sd32768) return 16'sh8000;
    return v[EW-1:0];
  endfunction : sat

  function automatic logic signed [39:0] mulq8(
    input logic signed [23:0] a, input logic [15:0] c);
    logic signed [39:0] p;
    p = a * $signed({1'b0, c});
    return p >>> 8;
  endfunction : mulq8

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    diodes_t            s1;
    diodes_t            s2;
    logic [4:0]         vref;
    logic               vauto;
    focus_state_t       fst;
    logic [$clog2(SAMPLE_DIV)-1:0] div;
    logic [1:0]         phase;
    logic signed [EW-1:0] ratio_ab;
    logic signed [EW-1:0] fe;
    logic signed [EW-1:0] fe_prev;
    logic signed [23:0] integ;
    logic signed [EW-1:0] lp;
    logic signed [EW-1:0] drive;
    logic [15:0]        gain;
    logic [15:0]        lead;
    logic signed [EW-1:0] ramp;
    logic               ramp_dn;
    logic               focus_ok_flag;
    logic [31:0]        lost_cnt;
    logic [31:0]        rst_cnt;
    logic               lost;
    logic signed [EW-1:0] re;
    logic signed [EW-1:0] re_off;
    logic               tpf;
    logic [5:0]         agc_cnt;
    logic               closed;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic               div_start;
  logic signed [11:0] div_num;
  logic [11:0]        div_den;
  logic signed [EW-1:0] div_q;
  logic               div_done;
  logic               tick;
  logic [11:0]        ca_sum;

  // Pins are sampled twice before any arithmetic reads them
  assign ca_sum = 12'(st_r.s2.central_diode_a) + 12'(st_r.s2.central_diode_b)
                + 12'(st_r.s2.central_diode_c) + 12'(st_r.s2.central_diode_d);
  assign tick   = (st_r.div == '0);

  always_comb begin
    div_num = '0;
    div_den = '0;
    if (st_r.phase == 2'h1) begin
      div_num = 12'(st_r.s2.central_diode_c) - 12'(st_r.s2.central_diode_d);
      div_den = 12'(st_r.s2.central_diode_c) + 12'(st_r.s2.central_diode_d);
    end else begin
      div_num = 12'(st_r.s2.central_diode_a) - 12'(st_r.s2.central_diode_b);
      div_den = 12'(st_r.s2.central_diode_a) + 12'(st_r.s2.central_diode_b);
    end
  end
  // Phase 0 idle, 1 first ratio busy, 2 second ratio busy; a tick that
  // finds the divider busy is skipped rather than queued
  assign div_start = (tick && st_r.phase == 2'h0)
                   || (div_done && st_r.phase == 2'h1 && !knife_edge_i);

  focus_divider focus_divider_i (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (div_start),
    .num_i     (div_num),
    .den_i     (div_den),
    .quot_o    (div_q),
    .done_o    (div_done)
  );

  always_comb begin
    logic signed [39:0] acc;
    logic signed [EW-1:0] diff;
    logic signed [EW-1:0] err;
    logic signed [EW-1:0] inj;
    acc    = '0;
    diff   = '0;
    err    = '0;
    inj    = '0;
    st_nxt = st_r;
    st_nxt.s1  = diodes_i;
    st_nxt.s2  = st_r.s1;
    st_nxt.div = st_r.div + 1'b1;

    // ---------------------------------------------------------------
    // Converter reference
    // ---------------------------------------------------------------
    // RL1 stepped reference level
    if (vref_cmd_i) begin
      case (vref_op_i)
        VREF_SET: begin
          st_nxt.vref  = VREF_PRESET;
          st_nxt.vauto = 1'b0;
        end
        VREF_UP: begin
          if (st_r.vref != VREF_MAX) st_nxt.vref = st_r.vref + 5'h01;
        end
        VREF_DOWN: begin
          if (st_r.vref != 5'h00) st_nxt.vref = st_r.vref - 5'h01;
        end
        // RL2 automatic reference mode
        default: st_nxt.vauto = 1'b1;
      endcase
    end

    // ---------------------------------------------------------------
    // Focus error formation
    // ---------------------------------------------------------------
    if (tick && st_r.phase == 2'h0) st_nxt.phase = 2'h1;
    if (div_done && st_r.phase == 2'h1) begin
      st_nxt.ratio_ab = div_q;
      st_nxt.phase    = 2'h2;
      // RL4 single knife edge doubles ratio
      if (knife_edge_i) begin
        st_nxt.fe_prev = st_r.fe;
        st_nxt.fe      = sat(40'(div_q) <<< 1);
        st_nxt.phase   = 2'h0;
      end
    end else if (div_done && st_r.phase == 2'h2) begin
      // RL3 difference of the two ratios
      st_nxt.fe_prev = st_r.fe;
      st_nxt.fe      = sat(40'(st_r.ratio_ab) - 40'(div_q));
      st_nxt.phase   = 2'h0;
    end

    // ---------------------------------------------------------------
    // Radial error and track position
    // ---------------------------------------------------------------
    diff = EW'(st_r.s2.satellite_diode_a) - EW'(st_r.s2.satellite_diode_b);
    // RL7 gain plus offset scaling
    acc = mulq8(24'(diff), coeffs_i.radial_gain_coefficient)
        + mulq8(24'(diff), coeffs_i.radial_offset_coefficient);
    // RL8 capture standing offset at start-up
    if (radial_init_i) st_nxt.re_off = sat(acc);
    st_nxt.re = sat(acc - 40'(st_r.re_off));
    // RL9 sign of weighted sum difference, compared signed
    acc = mulq8(24'(EW'(st_r.s2.satellite_diode_a)
        + EW'(st_r.s2.satellite_diode_b)), coeffs_i.sum_weight);
    st_nxt.tpf = $signed(40'(ca_sum)) >= acc;

    // ---------------------------------------------------------------
    // Focus ok, drop-out and loss
    // ---------------------------------------------------------------
    // RL6 RL11 aperture against start level
    if (ca_sum >= coeffs_i.start_aperture_level) st_nxt.focus_ok_flag = 1'b1;
    // RL14 drop clears ok
    if (ca_sum < coeffs_i.drop_aperture_level) st_nxt.focus_ok_flag = 1'b0;
    st_nxt.lost = 1'b0;
    if (st_r.focus_ok_flag || st_r.fst == ST_IDLE) begin
      st_nxt.lost_cnt = '0;
    end else if (st_r.lost_cnt != LOST_CYCLES) begin
      st_nxt.lost_cnt = st_r.lost_cnt + 32'h1;
    end

    // ---------------------------------------------------------------
    // Gain switching
    // ---------------------------------------------------------------
    // RL17 gain and integrator scale together unless a sweep preset or closed-loop tick overwrites integ in that cycle
    if (gain_up_i && st_r.gain[15] == 1'b0) begin
      st_nxt.gain  = st_r.gain << 1;
      st_nxt.integ = st_r.integ >>> 1;
      // RL18 derivative switched with gain
      st_nxt.lead  = new_lead_i;
    end else if (gain_down_i && st_r.gain > 16'h0001) begin
      st_nxt.gain  = st_r.gain >> 1;
      st_nxt.integ = st_r.integ <<< 1;
      st_nxt.lead  = new_lead_i;
    end

    // ---------------------------------------------------------------
    // Focus sequencer
    // ---------------------------------------------------------------
    st_nxt.closed = (st_r.fst == ST_CLOSED) || (st_r.fst == ST_DROP);
    if (st_r.fst != ST_IDLE && st_r.fst != ST_CLOSED
        && st_r.fst != ST_DROP && st_r.rst_cnt != RESTART_CYCLES) begin
      st_nxt.rst_cnt = st_r.rst_cnt + 32'h1;
    end
    case (st_r.fst)
      ST_IDLE: begin
        // RL21 coefficients loaded before start
        if (focus_start_i) begin
          st_nxt.fst     = ST_SWEEP;
          st_nxt.gain    = coeffs_i.foc_gain;
          st_nxt.lead    = coeffs_i.focus_setting_word_one;
          st_nxt.ramp    = coeffs_i.ramp_offset;
          st_nxt.rst_cnt = '0;
        end
      end
      ST_SWEEP, ST_ARMED: begin
        // RL10 triangle around offset
        if (tick) begin
          if (st_r.ramp_dn) begin
            st_nxt.ramp = st_r.ramp - coeffs_i.ramp_incr;
            if (st_r.ramp <= $signed(coeffs_i.ramp_offset
                                     - coeffs_i.ramp_height))
              st_nxt.ramp_dn = 1'b0;
          end else begin
            st_nxt.ramp = st_r.ramp + coeffs_i.ramp_incr;
            if (st_r.ramp >= $signed(coeffs_i.ramp_offset
                                     + coeffs_i.ramp_height))
              st_nxt.ramp_dn = 1'b1;
          end
        end
        st_nxt.drive = st_r.ramp;
        st_nxt.integ = 24'(st_r.ramp);
        // RL16 retry the sweep once the restart span runs out
        if (st_r.rst_cnt == RESTART_CYCLES) begin
          st_nxt.fst     = ST_SWEEP;
          st_nxt.rst_cnt = '0;
          st_nxt.ramp    = coeffs_i.ramp_offset;
        end
        if (st_r.fst == ST_SWEEP && st_r.focus_ok_flag
            && (st_r.fe >= $signed(coeffs_i.start_error_level)
                || st_r.fe <= -$signed(coeffs_i.start_error_level)))
          st_nxt.fst = ST_ARMED;
        // RL12 close at zero crossing
        if (st_r.fst == ST_ARMED && st_r.focus_ok_flag
            && (st_r.fe[EW-1] != st_r.fe_prev[EW-1]))
          st_nxt.fst = ST_CLOSED;
      end
      ST_CLOSED, ST_DROP: begin
        st_nxt.fst = st_r.focus_ok_flag ? ST_CLOSED : ST_DROP;
        // RL15 RL20 loss after 3 ms
        if (st_r.lost_cnt == LOST_CYCLES) begin
          st_nxt.lost    = 1'b1;
          st_nxt.fst     = ST_SWEEP;
          st_nxt.rst_cnt = '0;
          st_nxt.ramp    = coeffs_i.ramp_offset;
        end
      end
      default: st_nxt.fst = ST_IDLE;
    endcase
    if (!focus_start_i) st_nxt.fst = ST_IDLE;

    // ---------------------------------------------------------------
    // PID loop, one update per sample tick
    // ---------------------------------------------------------------
    // RL19 square test signal while enabled
    if (tick) st_nxt.agc_cnt = st_r.agc_cnt + 6'h01;
    inj = (agc_enable_i && st_r.closed) ? (st_r.agc_cnt[5] ? 16'sh0040
                                                          : -16'sh0040)
                                        : 16'sh0000;
    err = sat(40'(st_r.fe) + 40'(inj));
    if (tick && (st_r.fst == ST_CLOSED || st_r.fst == ST_DROP)) begin
      // RL5 RL13 PID with noise filter and gain
      // RL14 integrator holds during drop
      if (st_r.fst == ST_CLOSED)
        st_nxt.integ = 24'(sat(40'(st_r.integ)
                     + mulq8(24'(err), coeffs_i.foc_int)));
      acc = 40'(st_r.integ)
          + mulq8(24'(err), coeffs_i.focus_setting_word_three)
          + mulq8(24'(err - st_r.fe_prev), st_r.lead);
      acc = mulq8(24'(sat(acc)), st_r.gain);
      st_nxt.lp = sat(40'(st_r.lp) + mulq8(24'(sat(acc - 40'(st_r.lp))),
                  coeffs_i.focus_setting_word_two));
      st_nxt.drive = st_r.lp;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r      <= '0;
      st_r.vref <= VREF_PRESET;
      st_r.fst  <= ST_IDLE;
      st_r.gain <= GAIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign converter_upper_reference_o = st_r.vref;
  assign vref_auto_o                 = st_r.vauto;
  assign normalised_focus_error_o    = st_r.fe;
  assign focus_drive_o               = st_r.drive;
  assign scaled_radial_error_o       = st_r.re;
  assign track_position_flag_o       = st_r.tpf;
  assign focus_ok_flag_o             = st_r.focus_ok_flag;
  assign focus_closed_o              = st_r.closed;
  assign focus_lost_o                = st_r.lost;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_set_cmd;
    vref_cmd_i && vref_op_i == VREF_SET;
  endsequence

  a_vref_preset: assert property (s_set_cmd |=> // RL1
    st_r.vref == VREF_PRESET && !st_r.vauto)
    else $error("preset level not applied");
  a_vref_auto: assert property (vref_cmd_i && vref_op_i == VREF_AUTO // RL2
    |=> st_r.vauto) else $error("auto mode not entered");
  a_drop_clears_ok: assert property ( // RL14
    ca_sum < coeffs_i.drop_aperture_level |=> !st_r.focus_ok_flag)
    else $error("focus ok kept below drop level");
  a_start_sets_ok: assert property ( // RL11
    ca_sum >= coeffs_i.start_aperture_level
    && ca_sum >= coeffs_i.drop_aperture_level |=> st_r.focus_ok_flag)
    else $error("focus ok not set at start level");
  a_lost_pulse: assert property (st_r.lost |=> !st_r.lost) // RL20
    else $error("lost event longer than one cycle");
  a_lost_cause: assert property ($rose(st_r.lost) |-> // RL15
    $past(st_r.lost_cnt) == LOST_CYCLES) else $error("early loss");
  a_integ_hold: assert property (tick && st_r.fst == ST_DROP // RL14
    && !gain_up_i && !gain_down_i && focus_start_i
    && st_r.lost_cnt != LOST_CYCLES |=> $stable(st_r.integ))
    else $error("integrator moved in drop");
  a_gain_up: assert property (gain_up_i && !st_r.gain[15] // RL17
    |=> st_r.gain == $past(st_r.gain) << 1) else $error("gain not doubled");
  a_close_cross: assert property ($rose(st_r.closed) // RL12
    |-> $past(st_r.fst, 2) == ST_ARMED) else $error("closed without arming");

endmodule : focus_servo

// *** hdl/focus_servo_pkg.sv ***
// Constants, types and carriers for the focus servo conditioning block.
// Assumes a single 20 MHz clock and a coefficient source that holds
// its words stable while the block runs.
// Contract
// RL1 - 32 reference levels, preset 2.5 V, step
// RL2 - Preset may select automatic reference mode
// RL3 - Normal focus error from four diodes
// RL4 - Single knife edge doubles one ratio
// RL5 - Focus error feeds PID filter
// RL6 - Focus ok from aperture versus level
// RL7 - Radial error times gain plus offset
// RL8 - Radial offset removed at disc start
// RL9 - Track flag sign of weighted difference
// RL10 - Triangle sweep from three parameters
// RL11 - Start aperture level sets focus ok
// RL12 - Loop closes at next error zero crossing
// RL13 - Five coefficients incl noise filter, gain
// RL14 - Drop level clears ok, freezes integrator
// RL15 - Ok false beyond 3 ms: restart
// RL16 - Restart closes loop within 300 ms
// RL17 - Gain double or halve, integrator rescaled; code loses the rescale in sweep or on a closed-loop tick
// RL18 - Derivative may change with gain switch
// RL19 - Gain control injects test signal briefly
// RL20 - Focus lost event after 3 ms
// RL21 - Host loads coefficients before start-up
package focus_servo_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned LOST_TIME_US  = 3000;
  localparam int unsigned LOST_CYCLES   =
    (CLK_HZ / 1_000_000) * LOST_TIME_US;
  localparam int unsigned RESTART_MS    = 300;
  localparam int unsigned RESTART_CYCLES = (CLK_HZ / 1000) * RESTART_MS;
  localparam int unsigned SAMPLE_DIV    = 16;
  localparam int unsigned AGC_PERIOD    = 64;

  // ---------------------------------------------------------------
  // Widths, reference and reset values
  // ---------------------------------------------------------------
  localparam int unsigned DW            = 10;
  localparam int unsigned EW            = 16;
  localparam logic [4:0]  VREF_PRESET   = 5'h13;
  localparam logic [4:0]  VREF_MAX      = 5'h1F;
  localparam logic [15:0] GAIN_RST      = 16'h0100;

  typedef enum logic [1:0] {
    VREF_SET  = 2'h0,
    VREF_UP   = 2'h1,
    VREF_DOWN = 2'h2,
    VREF_AUTO = 2'h3
  } vref_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SWEEP = 5'h02,
    ST_ARMED = 5'h04,
    ST_CLOSED = 5'h08,
    ST_DROP  = 5'h10
  } focus_state_t;

  typedef struct packed {
    logic [DW-1:0] central_diode_a;
    logic [DW-1:0] central_diode_b;
    logic [DW-1:0] central_diode_c;
    logic [DW-1:0] central_diode_d;
    logic [DW-1:0] satellite_diode_a;
    logic [DW-1:0] satellite_diode_b;
  } diodes_t;

  typedef struct packed {
    logic [15:0] foc_int;
    logic [15:0] focus_setting_word_one;
    logic [15:0] focus_setting_word_two;
    logic [15:0] focus_setting_word_three;
    logic [15:0] foc_gain;
    logic [15:0] ramp_height;
    logic [15:0] ramp_offset;
    logic [15:0] ramp_incr;
    logic [11:0] start_aperture_level;
    logic [11:0] drop_aperture_level;
    logic [15:0] start_error_level;
    logic [15:0] radial_gain_coefficient;
    logic [15:0] radial_offset_coefficient;
    logic [15:0] sum_weight;
  } coeffs_t;

endpackage : focus_servo_pkg

// *** testbench/photo_front_model.sv ***
// Photodetector converters and coefficient latch facing the servo.
// Assumes the bench gives each diode current as a converter code.
`timescale 1ns/100ps
module photo_front_model
  import focus_servo_pkg::*;
(
  input  wire logic    ref_clk_i,
  input  wire logic    resetn_i,
  input  wire diodes_t level_i,
  output diodes_t      diodes_o,
  output coeffs_t      coeffs_o
);
  // ---------------------------------------------------------------
  // Coefficients
  // ---------------------------------------------------------------
  // words held static
  assign coeffs_o = '{foc_int: 16'h0010, focus_setting_word_one: 16'h0020,
    focus_setting_word_two: 16'h0040, focus_setting_word_three: 16'h0100,
    foc_gain: GAIN_RST, ramp_height: 16'h0400, ramp_offset: 16'h0000,
    ramp_incr: 16'h0010, start_aperture_level: 12'h200,
    drop_aperture_level: 12'h080, start_error_level: 16'h1000,
    radial_gain_coefficient: 16'h0100, radial_offset_coefficient: 16'h0080,
    sum_weight: 16'h0100};

  // ---------------------------------------------------------------
  // Converters
  // ---------------------------------------------------------------
  // One code per clock; nothing valid while held in reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      diodes_o <= '0;
    end else begin
      diodes_o <= level_i;
    end
  end
endmodule : photo_front_model

// *** testbench/test_focus_servo.sv ***
// Self-checking bench for the focus servo conditioning block.
// Assumes a 20 MHz clock and the converter model in front of it.
`timescale 1ns/100ps
module test_focus_servo
  import focus_servo_pkg::*;
;
  logic             ref_clk_i   = 1'b0;
  logic             resetn_i    = 1'b0;
  diodes_t          level       = '0;
  diodes_t          diodes;
  coeffs_t          coeffs;
  logic             knife_edge  = 1'b0;
  logic             focus_start = 1'b0;
  logic             vref_cmd    = 1'b0;
  vref_cmd_t        vref_op     = VREF_SET;
  logic             gain_up     = 1'b0;
  logic             gain_down   = 1'b0;
  logic [15:0]      new_lead    = 16'h0020;
  logic [4:0]       vref_level;
  logic             vref_auto, track_flag, ok_flag, closed, lost;
  logic signed [EW-1:0] fe, drive, radial;
  logic             radial_init = 1'b0;
  logic             agc_enable  = 1'b0;
  logic [15:0]      vref_word;
  int               num_errors  = 0;
  int               cmp_count   = 0;
  int               n;

  always #25 ref_clk_i = ~ref_clk_i;
  assign vref_word = 16'(vref_level);

  photo_front_model photo_front_model_i (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .level_i(level), .diodes_o(diodes),
    .coeffs_o(coeffs));

  focus_servo focus_servo_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .diodes_i(diodes), .coeffs_i(coeffs), .knife_edge_i(knife_edge),
    .focus_start_i(focus_start), .vref_cmd_i(vref_cmd),
    .vref_op_i(vref_op), .gain_up_i(gain_up), .gain_down_i(gain_down),
    .new_lead_i(new_lead), .agc_enable_i(agc_enable),
    .radial_init_i(radial_init),
    .converter_upper_reference_o(vref_level), .vref_auto_o(vref_auto),
    .normalised_focus_error_o(fe), .focus_drive_o(drive),
    .scaled_radial_error_o(radial), .track_position_flag_o(track_flag),
    .focus_ok_flag_o(ok_flag), .focus_closed_o(closed),
    .focus_lost_o(lost));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cmp_word(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string what, input logic exp,
                          input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  // Fixed settle: three sync stages, a sample tick and the divider
  task automatic set_diodes(input logic [9:0] a, b, c, d, ra, rb);
    @(posedge ref_clk_i);
    level <= '{a, b, c, d, ra, rb};
    repeat (120) @(posedge ref_clk_i);
  endtask : set_diodes

  task automatic vref_step(input vref_cmd_t op);
    @(posedge ref_clk_i);
    vref_cmd <= 1'b1;
    vref_op  <= op;
    @(posedge ref_clk_i);
    vref_cmd <= 1'b0;
    @(posedge ref_clk_i);
  endtask : vref_step

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    num_errors++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp_word("reference after reset", {11'h000, VREF_PRESET}, vref_word);
    cmp_flag("closed after reset", 1'b0, closed);
    vref_step(VREF_UP);
    cmp_word("reference up", 16'h0014, vref_word);
    vref_step(VREF_DOWN);
    vref_step(VREF_DOWN);
    cmp_word("reference down", 16'h0012, vref_word);
    for (n = 0; n < 15; n++) vref_step(VREF_UP);
    cmp_word("reference top", {11'h000, VREF_MAX}, vref_word);
    for (n = 0; n < 40; n++) vref_step(VREF_DOWN);
    cmp_word("reference bottom", 16'h0000, vref_word);
    vref_step(VREF_AUTO);
    cmp_flag("automatic reference", 1'b1, vref_auto);
    vref_step(VREF_SET);
    cmp_word("reference preset", 16'h0013, vref_word);
    cmp_flag("stepped reference", 1'b0, vref_auto);
    $display("test reference levels done");

    set_diodes(10'h12C, 10'h064, 10'h0C8, 10'h0C8, 10'h12C, 10'h0C8);
    cmp_word("focus error normal", 16'h2000, fe);
    cmp_word("radial error", 16'h0096, radial);
    cmp_flag("track flag over track", 1'b1, track_flag);
    radial_init <= 1'b1; // offset capture
    repeat (4) @(posedge ref_clk_i);
    radial_init <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    cmp_word("radial error offset removed", 16'h0000, radial);
    knife_edge <= 1'b1;
    repeat (120) @(posedge ref_clk_i);
    cmp_word("focus error knife edge", 16'h4000, fe);
    knife_edge <= 1'b0;
    set_diodes(10'h12C, 10'h064, 10'h0C8, 10'h0C8, 10'h1F4, 10'h1F4);
    cmp_flag("track flag off track", 1'b0, track_flag);
    cmp_word("radial error less offset", 16'hFF6A, radial);
    $display("test signal conditioning done");

    focus_start <= 1'b1;
    for (n = 0; n < 400 && ok_flag !== 1'b1; n++) @(posedge ref_clk_i);
    cmp_flag("focus ok at start level", 1'b1, ok_flag);
    set_diodes(10'h064, 10'h12C, 10'h0C8, 10'h0C8, 10'h12C, 10'h0C8);
    for (n = 0; n < 2000 && closed !== 1'b1; n++) @(posedge ref_clk_i);
    cmp_flag("loop closed at crossing", 1'b1, closed);
    repeat (40) @(posedge ref_clk_i);
    cmp_flag("drive active", 1'b1, drive != 16'h0000);
    agc_enable <= 1'b1; // brief test signal
    repeat (64) @(posedge ref_clk_i);
    agc_enable <= 1'b0;
    cmp_flag("closed with test signal", 1'b1, closed);
    gain_up   <= 1'b1;
    new_lead  <= 16'h0030;
    @(posedge ref_clk_i);
    gain_up   <= 1'b0;
    gain_down <= 1'b1;
    @(posedge ref_clk_i);
    gain_down <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    cmp_flag("closed across gain switch", 1'b1, closed);
    $display("test focus start-up done");

    level <= '{10'h00A, 10'h00A, 10'h00A, 10'h00A, 10'h12C, 10'h0C8};
    // Sample away from the launching edge: the loss pulse stands one cycle
    for (n = 0; n < 61000 && lost !== 1'b1; n++) begin
      @(negedge ref_clk_i);
      if (n == 100) cmp_flag("focus ok after drop", 1'b0, ok_flag);
    end
    cmp_flag("loss after hold time", 1'b1,
             n >= LOST_CYCLES && n <= LOST_CYCLES + 100);
    @(negedge ref_clk_i);
    cmp_flag("loss pulse ends", 1'b0, lost);
    cmp_flag("restart leaves loop open", 1'b0, closed);
    $display("test focus loss done");
    report_and_stop();
  end
endmodule : test_focus_servo
